// ### core/gpps_chan_mem.sv
// per-channel duty and trim holding storage with registered read port
`timescale 1ns/1ps
`default_nettype none
module gpps_chan_mem
  import gpps_pkg::*;
#(
  parameter int unsigned DEPTH = gpps_pkg::CHAN_N
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic wr_trim_i,
  input wire logic [gpps_pkg::CIDX_W-1:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [gpps_pkg::CIDX_W-1:0] rd_addr_i,
  output logic [gpps_pkg::DUTY_W-1:0] rd_duty_o,
  output logic [gpps_pkg::TRIM_W-1:0] rd_trim_o,
  output logic [DEPTH*gpps_pkg::DUTY_W-1:0] duty_flat_o,
  output logic [DEPTH*gpps_pkg::TRIM_W-1:0] trim_flat_o
);
  logic [DUTY_W-1:0] duty [DEPTH];
  logic [TRIM_W-1:0] trim [DEPTH];

  // storage cleared to zero on reset so every channel starts off
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        duty[i] <= DUTY_RST;
        trim[i] <= TRIM_RST;
      end
    end else if (wr_en_i) begin
      if (wr_trim_i) begin
        trim[wr_addr_i] <= wr_data_i[TRIM_W-1:0];
      end else begin
        duty[wr_addr_i] <= wr_data_i[DUTY_W-1:0];
      end
    end
  end

  // registered read for the bus side
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_duty_o <= DUTY_RST;
      rd_trim_o <= TRIM_RST;
    end else begin
      rd_duty_o <= duty[rd_addr_i];
      rd_trim_o <= trim[rd_addr_i];
    end
  end

  // parallel view for the comparators and trim scaler
  for (genvar g = 0; g < DEPTH; g++) begin : g_flat
    assign duty_flat_o[g*DUTY_W +: DUTY_W] = duty[g];
    assign trim_flat_o[g*TRIM_W +: TRIM_W] = trim[g];
  end
endmodule // gpps_chan_mem
`default_nettype wire

// ### core/gpps_pkg.sv
// shared constants for the grayscale pwm and precharge sequencer
package gpps_pkg;
  // channel geometry
  localparam int unsigned CHAN_N = 32;
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned TRIM_W = 6;
  localparam int unsigned LEVEL_W = 8;   // levels run up to 189
  localparam int unsigned CIDX_W = 5;
  localparam int unsigned ADDR_W = 12;
  // dimming period split, in dimming-clock cycles
  localparam int unsigned PERIOD_CYCLES = 4096;
  localparam logic [11:0] TRACK_CYCLES = 12'hE00;   // 3584 low cycles
  localparam int unsigned CHARGE_CYCLES = 512;
  // trim scaling: level = TRIM_BASE + 2 * code, in units of nominal/126
  localparam logic [7:0] TRIM_BASE = 8'h3F;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] SINK_OFS = 12'h008;
  localparam logic [11:0] FAULT_OFS = 12'h00C;
  localparam logic [4:0] CHAN_PAGE = 5'h02;         // window 0x100..0x17C
  // control field positions and reset values
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_FS_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_FS_RST = 1'b0;
  localparam logic [11:0] DUTY_RST = 12'h000;
  localparam logic [5:0] TRIM_RST = 6'h00;
  // status field positions
  localparam int unsigned ST_CHARGE_BIT = 16;
  localparam int unsigned ST_HEAD_BIT = 17;
  localparam int unsigned ST_RUN_BIT = 18;
endpackage

// ### core/gpps_seq.sv
// grayscale pwm and precharge sequencer with apb register slave
`timescale 1ns/1ps
`default_nettype none
module gpps_seq
  import gpps_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [gpps_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // dimming clock and channel status
  input wire logic dimming_clock_in_i,
  input wire logic [gpps_pkg::CHAN_N-1:0] channel_fault_i,
  // sink control and loop selection
  output logic [gpps_pkg::CHAN_N-1:0] channel_sink_pins_o,
  output logic [gpps_pkg::CHAN_N*gpps_pkg::LEVEL_W-1:0] channel_sink_level_o,
  output logic bus_charge_phase_o,
  output logic headroom_tracking_loop_o
);
  import gpps_pkg::*;

  // control and sequencer state
  logic frame_control_bit_one;
  logic frame_kind_select;
  logic dim_prev;
  logic started;
  logic [DUTY_W-1:0] count;

  // memory connections
  logic [CHAN_N*DUTY_W-1:0] duty_flat;
  logic [CHAN_N*TRIM_W-1:0] trim_flat;
  logic [DUTY_W-1:0] rd_duty;
  logic [TRIM_W-1:0] rd_trim;

  // ---------------- apb decode ----------------
  wire access = psel_i & penable_i;
  wire first_access = access & ~pready_o;
  wire done = access & pready_o;
  wire wr_fire = done & pwrite_i;
  wire word_ok = (paddr_i[1:0] == 2'b00);
  wire hit_ctrl = word_ok & (paddr_i == CTRL_OFS);
  wire hit_status = word_ok & (paddr_i == STATUS_OFS);
  wire hit_sink = word_ok & (paddr_i == SINK_OFS);
  wire hit_fault = word_ok & (paddr_i == FAULT_OFS);
  wire hit_chan = word_ok & (paddr_i[11:7] == CHAN_PAGE);
  wire mapped = hit_ctrl | hit_status | hit_sink | hit_fault | hit_chan;
  wire [CIDX_W-1:0] chan_idx = paddr_i[6:2];

  // control register write; a cleared enable takes effect at this edge
  wire ctrl_wr = wr_fire & hit_ctrl;
  wire next_enable = ctrl_wr ? pwdata_i[CTRL_EN_BIT]
                             : frame_control_bit_one;
  wire next_fs = ctrl_wr ? pwdata_i[CTRL_FS_BIT] : frame_kind_select;

  // channel window write goes to duty or trim by frame select
  wire chan_wr = wr_fire & hit_chan;

  // read data selection
  wire [31:0] ctrl_word = {30'h0, frame_kind_select, frame_control_bit_one};
  wire [31:0] status_word = {13'h0, started, headroom_tracking_loop_o,
                             bus_charge_phase_o, 4'h0, count};
  wire [31:0] chan_word = frame_kind_select ? {26'h0, rd_trim}
                                            : {20'h0, rd_duty};
  wire [31:0] next_rdata = hit_ctrl ? ctrl_word :
                           hit_status ? status_word :
                           hit_sink ? channel_sink_pins_o :
                           hit_fault ? channel_fault_i :
                           hit_chan ? chan_word : 32'h0000_0000;

  // ---------------- dimming sequencer ----------------
  // dimming clock is synchronous; a rising edge is a one-cycle enable
  wire dim_edge = dimming_clock_in_i & ~dim_prev;
  wire [DUTY_W-1:0] cnt_inc = count + 12'h001;
  // a period begins on the first edge after enable or on wrap to zero
  wire period_start = next_enable & dim_edge &
                      (~started | (cnt_inc == 12'h000));
  wire [DUTY_W-1:0] next_count = ~next_enable ? 12'h000 :
                                 dim_edge ? cnt_inc :
                                 count;
  wire next_started = next_enable & (started | dim_edge);

  // per-channel waveforms share one counter, so all rising edges align
  logic [CHAN_N-1:0] next_sink;
  for (genvar g = 0; g < CHAN_N; g++) begin : g_chan
    wire [DUTY_W-1:0] duty_g = duty_flat[g*DUTY_W +: DUTY_W];
    assign next_sink[g] = ~next_enable ? 1'b0 :
                          period_start ? (duty_g != 12'h000) :
                          channel_sink_pins_o[g] &
                          (duty_g != next_count);
  end

  // inactive means off or faulted
  wire all_idle = &(~next_sink | channel_fault_i);
  wire next_charge = (~next_enable | ~next_started) ? 1'b1 :
                     period_start ? 1'b0 :
                     (next_count >= TRACK_CYCLES) ? 1'b1 :
                     all_idle ? 1'b1 :
                     bus_charge_phase_o;
  wire next_headroom = ~next_charge;

  // bus slave registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= first_access;
      pslverr_o <= first_access & ~mapped;
      prdata_o <= first_access ? next_rdata : prdata_o;
    end
  end

  // control bits, cleared by reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_control_bit_one <= CTRL_EN_RST;
      frame_kind_select <= CTRL_FS_RST;
    end else begin
      frame_control_bit_one <= next_enable;
      frame_kind_select <= next_fs;
    end
  end

  // counter, sinks and loop selection
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dim_prev <= 1'b0;
      started <= 1'b0;
      count <= 12'h000;
      channel_sink_pins_o <= 32'h0000_0000;
      bus_charge_phase_o <= 1'b1;
      headroom_tracking_loop_o <= 1'b0;
    end else begin
      dim_prev <= dimming_clock_in_i;   // paused clock holds state
      started <= next_started;
      count <= next_count;
      channel_sink_pins_o <= next_sink;
      bus_charge_phase_o <= next_charge;
      headroom_tracking_loop_o <= next_headroom;
    end
  end

  // holding registers for duty and trim
  gpps_chan_mem #(
    .DEPTH(CHAN_N)
  ) u_mem (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(chan_wr),
    .wr_trim_i(frame_kind_select),
    .wr_addr_i(chan_idx),
    .wr_data_i(pwdata_i),
    .rd_addr_i(chan_idx),
    .rd_duty_o(rd_duty),
    .rd_trim_o(rd_trim),
    .duty_flat_o(duty_flat),
    .trim_flat_o(trim_flat)
  );

  // linear current level per channel
  gpps_trim_scale #(
    .CHANS(CHAN_N)
  ) u_scale (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .trim_flat_i(trim_flat),
    .level_flat_o(channel_sink_level_o)
  );
endmodule // gpps_seq
`default_nettype wire

// ### core/gpps_trim_scale.sv
// converts each trim code into a linear sink current level
`timescale 1ns/1ps
`default_nettype none
module gpps_trim_scale
  import gpps_pkg::*;
#(
  parameter int unsigned CHANS = gpps_pkg::CHAN_N
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [CHANS*gpps_pkg::TRIM_W-1:0] trim_flat_i,
  output logic [CHANS*gpps_pkg::LEVEL_W-1:0] level_flat_o
);
  // level in nominal/126 units: code 0 gives 0.5x, code 63 gives 1.5x
  function automatic logic [LEVEL_W-1:0] trim_level(
    input logic [TRIM_W-1:0] code
  );
    // doubled code padded to the level width so code 63 cannot wrap
    trim_level = TRIM_BASE + {1'b0, code, 1'b0};
  endfunction

  // one register per channel level
  for (genvar g = 0; g < CHANS; g++) begin : g_lvl
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        level_flat_o[g*LEVEL_W +: LEVEL_W] <= TRIM_BASE;
      end else begin
        level_flat_o[g*LEVEL_W +: LEVEL_W] <=
          trim_level(trim_flat_i[g*TRIM_W +: TRIM_W]);
      end
    end
  end
endmodule // gpps_trim_scale
`default_nettype wire

// ### dv/gpps_far_model.sv
// dimming clock source on the far side
`timescale 1ns/1ps
`default_nettype none
module gpps_far_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  output logic dimming_clock_o
);
  logic [1:0] ph;
  // runs two high, two low; parked low while paused
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) ph <= 2'h0;
    else ph <= run_i ? ph + 2'h1 : 2'h0;
  end
  assign dimming_clock_o = ph[1];
endmodule // gpps_far_model
`default_nettype wire

// ### dv/gpps_seq_sva.sv
// port checker for the sequencer
`timescale 1ns/1ps
`default_nettype none
module gpps_seq_sva (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic dimming_clock_in_i,
  input wire logic [31:0] channel_sink_pins_o,
  input wire logic [255:0] channel_sink_level_o,
  input wire logic bus_charge_phase_o,
  input wire logic headroom_tracking_loop_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // a completed write of the control word with enable low
  wire off_wr = psel_i && penable_i && pready_o && pwrite_i &&
    paddr_i == 12'h000 && !pwdata_i[0];
  loop_inverse_a: assert property (
    headroom_tracking_loop_o != bus_charge_phase_o) else $error("loop sel");
  disable_off_a: assert property (
    off_wr |=> channel_sink_pins_o == 32'h0 && bus_charge_phase_o)
    else $error("disable");
  ready_wait_a: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("ready timing");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("err");
  rise_align_a: assert property (
    (channel_sink_pins_o & ~$past(channel_sink_pins_o)) != 32'h0
    |-> $fell(bus_charge_phase_o)) else $error("rise align");
  sink_hold_a: assert property (
    !dimming_clock_in_i && !$past(dimming_clock_in_i) && !psel_i &&
    !$past(psel_i) |=> $stable(channel_sink_pins_o)) else $error("sinks");
  charge_fall_a: assert property (
    $fell(bus_charge_phase_o) |-> $past(dimming_clock_in_i) &&
    !$past(dimming_clock_in_i, 2)) else $error("charge fall");
  level_range_a: assert property (
    channel_sink_level_o[0] && channel_sink_level_o[7:0] >= 8'h3F &&
    channel_sink_level_o[7:0] <= 8'hBD)
    else $error("level");
endmodule // gpps_seq_sva
bind gpps_seq gpps_seq_sva sva (.*);
`default_nettype wire

// ### dv/test_gpps_seq.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module test_gpps_seq;
  logic clock_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, pen = 1'b0;
  logic pwr = 1'b0, run = 1'b0, er, pready, perr, dim, chg, head, ec;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, flt = 32'h0, rd, prd, sinks;
  logic [31:0] seed = 32'h0000_0DB7;
  logic [255:0] lvl;
  int n_fail = 0, n_tests = 0, cyc = 0, c = 0, early = 0;
  int duty[32], trim[32];
  gpps_far_model far (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .run_i(run), .dimming_clock_o(dim));
  gpps_seq dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
    .dimming_clock_in_i(dim), .channel_fault_i(flt),
    .channel_sink_pins_o(sinks), .channel_sink_level_o(lvl),
    .bus_charge_phase_o(chg), .headroom_tracking_loop_o(head));
  // clock and hang guard
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // wait one dimming edge and compare with the model
  task automatic step();
    int g;
    logic [31:0] e;
    @(posedge dim);
    repeat (2) @(posedge clock_i);
    #1;
    c = (c + 1) % 4096;
    if (c == 0) early = 0;
    e = 32'h0;
    for (g = 0; g < 32; g++) e[g] = duty[g] != 0 && c < duty[g];
    if ((e & ~flt) == 32'h0) early = 1;
    ec = c >= 3584 || early == 1;
    chk(sinks, e);
    chk({31'h0, chg}, {31'h0, ec});
    chk({31'h0, head}, {31'h0, !ec});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    int g;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    for (g = 0; g < 32; g++) chk({24'h0, lvl[8*g +: 8]}, 32'h3F);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h2);
    for (g = 0; g < 32; g++) begin
      trim[g] = (g == 0) ? 63 : int'(rnd() & 32'h3F);
      apb(1'b1, 12'h100 + 12'(4 * g), 32'(trim[g]));
    end
    @(posedge clock_i);
    #1;
    for (g = 0; g < 32; g++) begin
      chk({24'h0, lvl[8*g +: 8]}, 32'(63 + 2 * trim[g]));
    end
    apb(1'b0, 12'h114, 32'h0);
    chk(rd, 32'(trim[5]));
    $display("test trims done");
    apb(1'b1, 12'h000, 32'h0);
    for (g = 0; g < 32; g++) begin
      // channel 3 stays lit so the mid-period duty write must turn it off
      duty[g] = (g == 31 || g == 3) ? 4095 :
                g < 2 ? g : int'(rnd() & 32'h3FF);
      apb(1'b1, 12'h100 + 12'(4 * g), 32'(duty[g]));
    end
    flt <= rnd() & 32'h7FFF_FFFF;
    apb(1'b1, 12'h000, 32'h1);
    @(posedge clock_i);
    #1;
    chk({30'h0, chg, head}, 32'h2);
    @(posedge clock_i) run <= 1'b1;
    for (g = 0; g < 5200; g++) begin
      step();
      if (c == 0) @(posedge clock_i) flt <= flt | 32'h8000_0000;
      if (g == 99) begin
        @(posedge clock_i) run <= 1'b0;
        duty[3] = c;
        apb(1'b1, 12'h10C, 32'(c));
        repeat (2) @(posedge clock_i);
        chk({31'h0, sinks[3]}, 32'h0);
        run <= 1'b1;
      end
    end
    $display("test dimming done");
    apb(1'b1, 12'h000, 32'h0);
    @(posedge clock_i);
    #1;
    chk({sinks[31:1], chg}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h0003_0FFF, 32'h0001_0000);
    $display("test disable done");
    finish_test();
  end
endmodule // test_gpps_seq
`default_nettype wire
